/* include/vadc_defs.vh */
// constants shared by the acquisition board host interface
`ifndef VADC_DEFS_VH
`define VADC_DEFS_VH

// clock period
`define VADC_CLK_NS        10

// address modifier codes accepted
`define VADC_AM_A          6'h29
`define VADC_AM_B          6'h2D
`define VADC_AM_C          6'h39
`define VADC_AM_D          6'h3D

// byte offsets inside the board window
`define VADC_OFS_CMD       9'h080
`define VADC_OFS_ID        9'h082
`define VADC_OFS_FLAGCLR   9'h084
`define VADC_OFS_GAIN      9'h086
`define VADC_OFS_CHAN      9'h088
`define VADC_OFS_FINAL     9'h08A
`define VADC_OFS_CONV      9'h08C
`define VADC_OFS_STAT2     9'h08E

// command register fields
`define VADC_CMD_TRIG_EN   0
`define VADC_CMD_CONV_RD   1
`define VADC_CMD_FAST      2
`define VADC_CMD_AUTOINC   3
`define VADC_CMD_RESCAN    4
`define VADC_CMD_EOC_IE    5
`define VADC_CMD_EOS_IE    6

// status register fields
`define VADC_ST_EOC        0
`define VADC_ST_EOS        1
`define VADC_ST_BUSY       2
`define VADC_ST_TRIG_ERR   3

// result coding jumper values
`define VADC_CODE_TWOS     2'b00

// reset values
`define VADC_RST_BYTE      8'h00

// timing
`define VADC_DTACK_STEP_NS 125
`define VADC_TRIG_MIN_NS   100
`define VADC_TRIG_MAX_NS   2000
`define VADC_SETTLE_NS     8000
`define VADC_TRIG_MIN_CYC  ((`VADC_TRIG_MIN_NS + `VADC_CLK_NS - 1) / `VADC_CLK_NS)
`define VADC_TRIG_MAX_CYC  (`VADC_TRIG_MAX_NS / `VADC_CLK_NS)
`define VADC_SETTLE_CYC    ((`VADC_SETTLE_NS + `VADC_CLK_NS - 1) / `VADC_CLK_NS)

`endif

/* hw/vadc_trig.v */
// external trigger edge detector and pulse width checker
`timescale 1ns/1ps
`default_nettype none
`include "vadc_defs.vh"

module vadc_trig (
  input  wire       i_clk,       // system clock
  input  wire       i_rst_n,     // synchronised reset, active low
  input  wire       i_trig_b,    // trigger pin, active low
  output reg        o_start,     // one cycle on a falling edge
  output reg        o_width_err  // one cycle when a pulse was too short or too long
);

  localparam integer MIN_I   = `VADC_TRIG_MIN_CYC;
  localparam integer MAX_I   = `VADC_TRIG_MAX_CYC;
  localparam [7:0]   MIN_CYC = MIN_I[7:0];
  localparam [7:0]   MAX_CYC = MAX_I[7:0];

  reg       trig_q;
  reg [7:0] width;
  reg       over;

  // falling edge starts a conversion, low time is measured alongside
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_q      <= 1'b1;
      width       <= 8'h00;
      over        <= 1'b0;
      o_start     <= 1'b0;
      o_width_err <= 1'b0;
    end else begin
      trig_q      <= i_trig_b;
      o_start     <= trig_q & ~i_trig_b;
      o_width_err <= 1'b0;
      if (trig_q & ~i_trig_b) begin
        width <= 8'h01;
        over  <= 1'b0;
      end else if (~trig_q & ~i_trig_b) begin
        if (width == MAX_CYC) begin
          if (!over) begin
            o_width_err <= 1'b1;
          end
          over <= 1'b1;
        end else begin
          width <= width + 8'h01;
        end
      end else if (~trig_q & i_trig_b) begin
        if (width < MIN_CYC) begin
          o_width_err <= 1'b1;
        end
      end
    end
  end

endmodule // vadc_trig
`default_nettype wire

/* hw/vadc_top.v */
// host bus slave, interrupter and acquisition control of the converter board
`timescale 1ns/1ps
`default_nettype none
`include "vadc_defs.vh"

module vadc_top (
  input  wire        i_clk,            // 100 MHz clock
  input  wire        i_rst_b,          // reset, active low, asynchronous
  input  wire        i_vme_as_b,       // address strobe
  input  wire        i_vme_ds0_b,      // data strobe, low byte
  input  wire        i_vme_ds1_b,      // data strobe, high byte
  input  wire        i_vme_write_b,    // low for a write
  input  wire [5:0]  i_vme_am,         // address modifier
  input  wire [15:1] i_vme_addr,       // short address lines
  input  wire [15:0] i_vme_data,       // data lines, incoming
  output reg  [15:0] o_vme_data,       // data lines, outgoing
  output wire        o_vme_data_oe,    // high while driving data
  output wire        o_vme_dtack_oe,   // high while pulling acknowledge low
  input  wire        i_vme_iack_b,     // interrupt acknowledge
  input  wire        i_vme_iackin_b,   // daisy chain in
  output wire        o_vme_iackout_b,  // daisy chain out
  output wire [6:0]  o_vme_irq_oe,     // bit k pulls request line k+1 low
  input  wire [6:0]  i_base_sw,        // base address switches, A15..A9
  input  wire [2:0]  i_dtack_sel,      // acknowledge delay jumper
  input  wire [2:0]  i_irq_sel,        // interrupt level jumper, 0 = none
  input  wire [1:0]  i_code_sel,       // result coding jumper
  input  wire        i_ext_trig_b,     // external trigger, active low
  input  wire        i_conv_eoc,       // converter end of conversion, high = done
  input  wire [15:0] i_conv_data,      // converter result, offset binary
  output reg         o_conv_start,     // one cycle convert command
  output wire [7:0]  o_chan,           // channel select
  output wire [2:0]  o_gain_sel,       // amplifier gain code
  output wire [1:0]  o_dout,           // general purpose outputs
  output wire        o_conv_done,      // conversion done flag
  output wire        o_scan_done,      // scan done flag
  output wire        o_settling,       // settling delay active
  output wire        o_ext_trig        // trigger exported, active high
);

  localparam [4:0] V_IDLE = 5'b00001;
  localparam [4:0] V_DLY  = 5'b00010;
  localparam [4:0] V_HOLD = 5'b00100;
  localparam [4:0] V_ACK  = 5'b01000;
  localparam [4:0] V_PASS = 5'b10000;
  localparam [2:0] A_IDLE   = 3'b001;
  localparam [2:0] A_SETTLE = 3'b010;
  localparam [2:0] A_CONV   = 3'b100;
  localparam integer SETTLE_I  = `VADC_SETTLE_CYC;
  localparam [9:0] SETTLE_CYC  = SETTLE_I[9:0];
  // byte offsets kept at their own width, word index cut from them
  localparam [8:0] O_CMD     = `VADC_OFS_CMD;
  localparam [8:0] O_ID      = `VADC_OFS_ID;
  localparam [8:0] O_FLAGCLR = `VADC_OFS_FLAGCLR;
  localparam [8:0] O_GAIN    = `VADC_OFS_GAIN;
  localparam [8:0] O_CHAN    = `VADC_OFS_CHAN;
  localparam [8:0] O_FINAL   = `VADC_OFS_FINAL;
  localparam [8:0] O_CONV    = `VADC_OFS_CONV;
  localparam [8:0] O_STAT2   = `VADC_OFS_STAT2;
  localparam [7:0] W_CMD     = O_CMD[8:1];
  localparam [7:0] W_ID      = O_ID[8:1];
  localparam [7:0] W_FLAGCLR = O_FLAGCLR[8:1];
  localparam [7:0] W_GAIN    = O_GAIN[8:1];
  localparam [7:0] W_CHAN    = O_CHAN[8:1];
  localparam [7:0] W_FINAL   = O_FINAL[8:1];
  localparam [7:0] W_CONV    = O_CONV[8:1];
  localparam [7:0] W_STAT2   = O_STAT2[8:1];

  reg        rst_m;
  reg        rst_n;
  reg [4:0]  vstate;
  reg [7:0]  vcnt;
  reg [7:0]  aword;
  reg        awrite;
  reg        aiack;
  reg [7:0]  vec;
  reg [7:0]  cmd;
  reg [7:0]  int_id;
  reg [7:0]  gain;
  reg [7:0]  start_chan;
  reg [7:0]  final_chan;
  reg [7:0]  cur_chan;
  reg [15:0] result;
  reg        eoc_flag;
  reg        eos_flag;
  reg        trig_err;
  reg [2:0]  astate;
  reg [9:0]  acnt;
  reg        eoc_q;
  reg        wr_flagclr;
  reg        wr_chan;
  reg        wr_conv;
  reg        rd_take;
  reg [15:0] next_rdata;
  wire       trig_start;
  wire       trig_werr;
  wire       am_ok;
  wire       board_sel;
  wire       iack_sel;
  wire       irq_pend;
  wire       eos_vec;
  wire       acq_busy;
  wire       start_req;
  wire       conv_fin;
  wire [31:0] dly_ns;
  wire [31:0] dly_cyc;

  // reset release through two flip-flops
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // trigger edge and width checking
  vadc_trig u_trig (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_trig_b    (i_ext_trig_b),
    .o_start     (trig_start),
    .o_width_err (trig_werr)
  );

  // cycle qualification from strobes, modifier and address
  assign am_ok = (i_vme_am == `VADC_AM_A) | (i_vme_am == `VADC_AM_B) |
                 (i_vme_am == `VADC_AM_C) | (i_vme_am == `VADC_AM_D);
  assign board_sel = ~i_vme_as_b & (~i_vme_ds0_b | ~i_vme_ds1_b) & i_vme_iack_b & am_ok &
                     (i_vme_addr[15:9] == i_base_sw);
  assign iack_sel = ~i_vme_as_b & ~i_vme_ds0_b & ~i_vme_iack_b & ~i_vme_iackin_b;

  // interrupt request and vector choice
  assign irq_pend = (eoc_flag & cmd[`VADC_CMD_EOC_IE]) | (eos_flag & cmd[`VADC_CMD_EOS_IE]);
  assign eos_vec = eos_flag & cmd[`VADC_CMD_EOS_IE] & cmd[`VADC_CMD_EOC_IE] & cmd[`VADC_CMD_AUTOINC];
  genvar lv;
  generate
    for (lv = 0; lv < 7; lv = lv + 1) begin : g_irq
      assign o_vme_irq_oe[lv] = irq_pend & ({29'h0000_0000, i_irq_sel} == lv + 1);
    end
  endgenerate

  // acknowledge delay in whole cycles, rounded up
  assign dly_ns  = ({29'h0000_0000, i_dtack_sel} + 32'h0000_0001) * `VADC_DTACK_STEP_NS;
  assign dly_cyc = (dly_ns + `VADC_CLK_NS - 1) / `VADC_CLK_NS;

  // read data selection
  always @* begin
    next_rdata = 16'h0000;
    case (aword)
      W_CMD, W_STAT2: next_rdata = {cmd, 4'h0, trig_err, acq_busy, eos_flag, eoc_flag};
      W_CHAN:         next_rdata = {8'h00, cur_chan};
      W_CONV:         next_rdata = result;
      default:        next_rdata = 16'h0000;
    endcase
  end

  // bus cycle state machine
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      vstate     <= V_IDLE;
      vcnt       <= 8'h00;
      aword      <= 8'h00;
      awrite     <= 1'b0;
      aiack      <= 1'b0;
      vec        <= 8'h00;
      o_vme_data <= 16'h0000;
      cmd        <= `VADC_RST_BYTE;
      int_id     <= `VADC_RST_BYTE;
      gain       <= `VADC_RST_BYTE;
      start_chan <= `VADC_RST_BYTE;
      final_chan <= `VADC_RST_BYTE;
      wr_flagclr <= 1'b0;
      wr_chan    <= 1'b0;
      wr_conv    <= 1'b0;
      rd_take    <= 1'b0;
    end else begin
      wr_flagclr <= 1'b0;
      wr_chan    <= 1'b0;
      wr_conv    <= 1'b0;
      rd_take    <= 1'b0;
      case (vstate)
        V_IDLE: begin
          if (board_sel) begin
            aword  <= i_vme_addr[8:1];
            awrite <= ~i_vme_write_b;
            aiack  <= 1'b0;
            vcnt   <= dly_cyc[7:0];
            vstate <= V_DLY;
            if (~i_vme_write_b & ~i_vme_ds0_b) begin
              case (i_vme_addr[8:1])
                W_CMD:     cmd <= i_vme_data[7:0];
                W_ID:      int_id <= i_vme_data[7:0];
                W_FLAGCLR: wr_flagclr <= 1'b1;
                W_GAIN:    gain <= i_vme_data[7:0];
                W_CHAN: begin
                  start_chan <= i_vme_data[7:0];
                  wr_chan    <= 1'b1;
                end
                W_FINAL:   final_chan <= i_vme_data[7:0];
                W_CONV:    wr_conv <= 1'b1;
                default:   wr_conv <= 1'b0;
              endcase
            end
          end else if (iack_sel) begin
            if (irq_pend & (i_irq_sel != 3'b000) & (i_vme_addr[3:1] == i_irq_sel)) begin
              aiack  <= 1'b1;
              awrite <= 1'b0;
              vec    <= eos_vec ? int_id + 8'h01 : int_id;
              vcnt   <= dly_cyc[7:0];
              vstate <= V_DLY;
            end else begin
              vstate <= V_PASS;
            end
          end
        end
        V_DLY: begin
          if (vcnt <= 8'h01) begin
            if (~aiack & ~awrite & (aword == W_CONV) & cmd[`VADC_CMD_FAST] & acq_busy) begin
              vstate <= V_HOLD;
            end else begin
              o_vme_data <= aiack ? {8'h00, vec} : next_rdata;
              rd_take    <= ~aiack & ~awrite & (aword == W_CONV);
              vstate     <= V_ACK;
            end
          end else begin
            vcnt <= vcnt - 8'h01;
          end
        end
        V_HOLD: begin
          if (!acq_busy) begin
            o_vme_data <= next_rdata;
            rd_take    <= 1'b1;
            vstate     <= V_ACK;
          end
        end
        V_ACK: begin
          if (i_vme_ds0_b & i_vme_ds1_b) begin
            vstate <= V_IDLE;
          end
        end
        V_PASS: begin
          if (i_vme_as_b) begin
            vstate <= V_IDLE;
          end
        end
        default: vstate <= V_IDLE;
      endcase
    end
  end

  // open drain style bus outputs
  assign o_vme_dtack_oe  = (vstate == V_ACK);
  assign o_vme_data_oe   = (vstate == V_ACK) & ~awrite;
  assign o_vme_iackout_b = ~((vstate == V_PASS) & ~i_vme_iackin_b);

  // conversion start sources
  assign start_req = wr_conv | (trig_start & cmd[`VADC_CMD_TRIG_EN]) |
                     (rd_take & cmd[`VADC_CMD_CONV_RD]);
  assign acq_busy  = (astate != A_IDLE);
  assign conv_fin  = (astate == A_CONV) & ~eoc_q & i_conv_eoc;

  // settling, conversion, channel stepping and done flags
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      astate       <= A_IDLE;
      acnt         <= 10'h000;
      eoc_q        <= 1'b1;
      cur_chan     <= `VADC_RST_BYTE;
      result       <= 16'h0000;
      eoc_flag     <= 1'b0;
      eos_flag     <= 1'b0;
      trig_err     <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      eoc_q        <= i_conv_eoc;
      o_conv_start <= 1'b0;
      case (astate)
        A_IDLE: begin
          if (start_req) begin
            acnt   <= SETTLE_CYC;
            astate <= A_SETTLE;
          end
        end
        A_SETTLE: begin
          if (acnt <= 10'h001) begin
            o_conv_start <= 1'b1;
            astate       <= A_CONV;
          end else begin
            acnt <= acnt - 10'h001;
          end
        end
        A_CONV: begin
          if (conv_fin) begin
            astate <= A_IDLE;
          end
        end
        default: astate <= A_IDLE;
      endcase
      if (conv_fin) begin
        // two's complement from offset binary by inverting the sign bit
        result <= (i_code_sel == `VADC_CODE_TWOS) ? {~i_conv_data[15], i_conv_data[14:0]}
                                                   : i_conv_data;
      end
      if (wr_chan) begin
        cur_chan <= start_chan;
      end else if (conv_fin & cmd[`VADC_CMD_AUTOINC]) begin
        if (cur_chan == final_chan) begin
          cur_chan <= cmd[`VADC_CMD_RESCAN] ? start_chan : cur_chan;
        end else begin
          cur_chan <= cur_chan + 8'h01;
        end
      end
      // a completion in the clearing cycle keeps its flag
      if (conv_fin) begin
        eoc_flag <= 1'b1;
      end else if (wr_flagclr | start_req) begin
        eoc_flag <= 1'b0;
      end
      if (conv_fin & (cur_chan == final_chan)) begin
        eos_flag <= 1'b1;
      end else if (wr_flagclr | wr_chan) begin
        eos_flag <= 1'b0;
      end
      if (trig_werr) begin
        trig_err <= 1'b1;
      end else if (wr_flagclr) begin
        trig_err <= 1'b0;
      end
    end
  end

  // expansion connector and amplifier controls
  assign o_chan      = cur_chan;
  assign o_gain_sel  = gain[2:0];
  assign o_dout      = gain[7:6];
  assign o_conv_done = eoc_flag;
  assign o_scan_done = eos_flag;
  assign o_settling  = (astate == A_SETTLE);
  assign o_ext_trig  = ~i_ext_trig_b;

endmodule // vadc_top
`default_nettype wire

/* dv/vadc_conv_model.sv */
// converter stand-in that answers each convert command after a set delay
`timescale 1ns/1ps
`default_nettype none

module vadc_conv_model (
  input  wire         i_clk,   // system clock
  input  wire         i_start, // convert command
  input  wire  [9:0]  i_delay, // cycles to finish
  input  wire  [15:0] i_value, // next result
  output logic        o_eoc,   // high when done
  output logic [15:0] o_data   // result
);
  logic [9:0] left;

  initial begin
    o_eoc = 1'b1;
    o_data = 16'h0000;
    left = 10'h000;
  end

  // data lines toggle while converting, so a stale result never looks valid
  always @(posedge i_clk) begin
    if (i_start) begin
      o_eoc <= 1'b0;
      left <= i_delay;
    end else if (!o_eoc) begin
      left <= left - 10'h001;
      o_data <= (left == 10'h001) ? i_value : ~o_data;
      o_eoc <= (left == 10'h001);
    end
  end
endmodule // vadc_conv_model

`default_nettype wire

/* dv/vadc_top_asserts.sv */
// assertions on the bus, interrupt and acquisition ports
`timescale 1ns/1ps
`default_nettype none

module vadc_top_asserts (
  input wire        i_clk,           // clock
  input wire        i_rst_b,         // reset
  input wire        i_vme_as_b,      // address strobe
  input wire        i_vme_ds0_b,     // strobe low
  input wire        i_vme_ds1_b,     // strobe high
  input wire        i_vme_write_b,   // direction
  input wire [5:0]  i_vme_am,        // modifier
  input wire [15:1] i_vme_addr,      // address
  input wire        i_vme_iack_b,    // acknowledge
  input wire        i_vme_iackin_b,  // chain in
  input wire [6:0]  i_base_sw,       // base
  input wire [2:0]  i_irq_sel,       // level
  input wire        o_vme_dtack_oe,  // ack drive
  input wire        o_vme_iackout_b, // chain out
  input wire [6:0]  o_vme_irq_oe,    // requests
  input wire [2:0]  o_gain_sel,      // gain
  input wire [1:0]  o_dout,          // outputs
  input wire        o_settling       // settling
);
  logic [11:0] settle_cnt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // length of the running settle window
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settle_cnt <= 12'h000;
    end else begin
      settle_cnt <= o_settling ? settle_cnt + 12'h001 : 12'h000;
    end
  end

  modifier_ok_a: assert property ($rose(o_vme_dtack_oe) && i_vme_iack_b
    |-> i_vme_am inside {6'h29, 6'h2D, 6'h39, 6'h3D}) else $error("answer to a foreign modifier");
  base_match_a: assert property ($rose(o_vme_dtack_oe) && i_vme_iack_b
    |-> i_vme_addr[15:9] == i_base_sw) else $error("answer to a foreign base");
  strobe_cause_a: assert property ($rose(o_vme_dtack_oe) |-> !i_vme_as_b && !i_vme_ds0_b
    && $past(i_vme_as_b, 12) == 1'b0) else $error("answer without a long enough strobe");
  hold_ack_a: assert property (o_vme_dtack_oe && !(i_vme_ds0_b && i_vme_ds1_b) |=> o_vme_dtack_oe)
    else $error("answer dropped under a strobe");
  drop_ack_a: assert property (o_vme_dtack_oe && i_vme_ds0_b && i_vme_ds1_b |-> ##[1:2] !o_vme_dtack_oe)
    else $error("answer held after release");
  irq_line_a: assert property (o_vme_irq_oe != 7'h00 |-> i_irq_sel != 3'h0
    && o_vme_irq_oe == 7'h01 << (i_irq_sel - 3'h1)) else $error("request on a wrong line");
  chain_pass_a: assert property (!o_vme_iackout_b |-> !i_vme_iackin_b && !i_vme_iack_b && !o_vme_dtack_oe)
    else $error("chain passed outside an acknowledge");
  settle_time_a: assert property ($fell(o_settling) |-> settle_cnt inside {[800:801]})
    else $error("settle window of wrong length");
  gain_cause_a: assert property (!$stable({o_gain_sel, o_dout})
    |-> $past(i_vme_as_b) == 1'b0 && $past(i_vme_write_b) == 1'b0) else $error("gain changed without a write");

  cover property ($fell(o_vme_iackout_b));
  cover property ($rose(o_vme_irq_oe[2]));
  cover property ($fell(o_settling));
endmodule // vadc_top_asserts

`default_nettype wire

/* dv/vadc_top_tb_top.sv */
// self-checking bench for the converter board host interface
`timescale 1ns/1ps
`default_nettype none
`include "vadc_defs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", n, e, a); end end

module vadc_top_tb_top;
  localparam logic [6:0] BASE = 7'h35;
  localparam logic [5:0] AMS[4] = '{`VADC_AM_A, `VADC_AM_B, `VADC_AM_C, `VADC_AM_D};
  logic        i_clk, i_rst_b, i_vme_as_b, i_vme_ds0_b, i_vme_ds1_b, i_vme_write_b, i_vme_iack_b, i_vme_iackin_b;
  logic        i_ext_trig_b, dt_q;
  logic [5:0]  i_vme_am;
  logic [15:1] i_vme_addr;
  logic [15:0] i_vme_data, val, ev;
  logic [6:0]  i_base_sw;
  logic [2:0]  i_dtack_sel, i_irq_sel;
  logic [1:0]  i_code_sel;
  logic [9:0]  cdly;
  logic [7:0]  id;
  logic [31:0] rv;
  wire         i_conv_eoc, o_vme_data_oe, o_vme_dtack_oe, o_vme_iackout_b, o_conv_start, o_conv_done;
  wire         o_scan_done, o_settling, o_ext_trig;
  wire  [15:0] i_conv_data, o_vme_data;
  wire  [6:0]  o_vme_irq_oe;
  wire  [7:0]  o_chan;
  wire  [2:0]  o_gain_sel;
  wire  [1:0]  o_dout;
  int          miscompares, checks_done, last_n, cycles;
  logic [15:0] exq[$];

  vadc_top i_vadc_top (.i_clk, .i_rst_b, .i_vme_as_b, .i_vme_ds0_b, .i_vme_ds1_b, .i_vme_write_b, .i_vme_am,
    .i_vme_addr, .i_vme_data, .o_vme_data, .o_vme_data_oe, .o_vme_dtack_oe, .i_vme_iack_b, .i_vme_iackin_b,
    .o_vme_iackout_b, .o_vme_irq_oe, .i_base_sw, .i_dtack_sel, .i_irq_sel, .i_code_sel, .i_ext_trig_b,
    .i_conv_eoc, .i_conv_data, .o_conv_start, .o_chan, .o_gain_sel, .o_dout, .o_conv_done, .o_scan_done,
    .o_settling, .o_ext_trig);
  vadc_conv_model i_vadc_conv_model (.i_clk, .i_start(o_conv_start), .i_delay(cdly), .i_value(val),
    .o_eoc(i_conv_eoc), .o_data(i_conv_data));

  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // read data checked against the oldest note as the answer rises
  always @(negedge i_clk) begin
    if (o_vme_dtack_oe === 1'b1 && dt_q !== 1'b1 && o_vme_data_oe === 1'b1) begin
      ev = exq.pop_front();
      `CHK("read data", ev, o_vme_data)
    end
    dt_q <= o_vme_dtack_oe;
  end

  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one bus or acknowledge cycle, strobes held until answered or given up
  task automatic cyc(input logic rd, ia, input logic [8:0] o, input logic [15:0] d, input logic ans = 1,
                     input int lat = 15, input logic [5:0] m = `VADC_AM_A);
    int n;
    n = 0;
    if (rd && ans) exq.push_back(d);
    i_vme_addr <= ia ? {12'h000, o[2:0]} : {BASE, o[8:1]};
    i_vme_data <= d;
    i_vme_am <= m;
    i_vme_write_b <= rd;
    i_vme_iack_b <= !ia;
    i_vme_iackin_b <= !ia;
    i_vme_as_b <= 1'b0;
    i_vme_ds0_b <= 1'b0;
    while (o_vme_dtack_oe !== 1'b1 && n < (ans ? 2000 : 150)) begin
      @(negedge i_clk);
      n++;
    end
    last_n = n;
    `CHK("answer", ans, o_vme_dtack_oe === 1'b1)
    if (lat > 0) `CHK("delay", lat, n)
    if (ia && !ans) `CHK("chain out", 1'b0, o_vme_iackout_b)
    @(posedge i_clk);
    i_vme_as_b <= 1'b1;
    i_vme_ds0_b <= 1'b1;
    i_vme_iack_b <= 1'b1;
    i_vme_iackin_b <= 1'b1;
    n = 0;
    while (o_vme_dtack_oe !== 1'b0 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    `CHK("release", 1'b0, o_vme_dtack_oe)
    @(posedge i_clk);
  endtask

  // waits for the conversion done flag
  task automatic wait_done;
    int n;
    n = 0;
    while (o_conv_done !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
  endtask

  // main sequence
  initial begin
    {i_rst_b, i_code_sel, i_dtack_sel, i_irq_sel, i_vme_am, i_vme_addr, i_vme_data, val} = '0;
    {i_vme_as_b, i_vme_ds0_b, i_vme_ds1_b, i_vme_write_b, i_vme_iack_b, i_vme_iackin_b, i_ext_trig_b} = '1;
    i_base_sw = BASE;
    cdly = 10'h028;
    rv = $urandom(32'hf081_0fe7);
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      rv = $urandom;
      i_dtack_sel <= k[2:0];
      cyc(0, 0, `VADC_OFS_GAIN, {8'h00, rv[1:0], 3'h0, k[2:0]}, 1, ((k + 1) * 125 + 9) / 10 + 2, AMS[k % 4]);
      `CHK("gain code", k[2:0], o_gain_sel)
      `CHK("outputs", rv[1:0], o_dout)
    end
    i_dtack_sel <= 3'h0;
    cyc(1, 0, `VADC_OFS_STAT2, 16'h0000, 0, 0, 6'h09);
    i_base_sw <= BASE ^ 7'h01;
    cyc(1, 0, `VADC_OFS_STAT2, 16'h0000, 0, 0);
    i_base_sw <= BASE;
    $display("gain, delay and decode test done");
    cyc(0, 0, `VADC_OFS_CHAN, 16'h0005, 1, 15, `VADC_AM_B);
    cyc(0, 0, `VADC_OFS_FINAL, 16'h0005, 1, 15, `VADC_AM_C);
    cyc(1, 0, `VADC_OFS_CHAN, 16'h0005, 1, 15, `VADC_AM_D);
    `CHK("channel out", 8'h05, o_chan)
    cyc(1, 0, 9'h1FE, 16'h0000);
    rv = $urandom;
    id = rv[7:0];
    val <= rv[31:16];
    i_irq_sel <= 3'h3;
    cyc(0, 0, `VADC_OFS_ID, {8'h00, id});
    cyc(0, 0, `VADC_OFS_CMD, 16'h0068);
    cyc(0, 0, `VADC_OFS_CONV, 16'h0000);
    wait_done();
    `CHK("scan done", 1'b1, o_scan_done)
    `CHK("request", 7'h04, o_vme_irq_oe)
    cyc(1, 0, `VADC_OFS_STAT2, 16'h6803);
    cyc(1, 0, `VADC_OFS_CONV, val ^ 16'h8000);
    cyc(1, 1, 9'h002, 16'h0000, 0, 0);
    cyc(1, 1, 9'h003, {8'h00, id + 8'h01});
    cyc(0, 0, `VADC_OFS_FLAGCLR, 16'h0000);
    `CHK("request gone", 7'h00, o_vme_irq_oe)
    $display("conversion and interrupt test done");
    rv = $urandom;
    val <= rv[15:0];
    cdly <= 10'h12C;
    i_code_sel <= 2'h1;
    cyc(0, 0, `VADC_OFS_CMD, 16'h0004);
    cyc(0, 0, `VADC_OFS_CONV, 16'h0000);
    cyc(1, 0, `VADC_OFS_CONV, val, 1, 0);
    `CHK("held for result", 1'b1, last_n > 1000)
    $display("fast mode test done");
    cyc(0, 0, `VADC_OFS_CMD, 16'h0001);
    i_ext_trig_b <= 1'b0;
    repeat (50) @(posedge i_clk);
    `CHK("trigger out", 1'b1, o_ext_trig)
    i_ext_trig_b <= 1'b1;
    repeat (3) @(negedge i_clk);
    `CHK("trigger start", 1'b1, o_settling)
    `CHK("notes left", 0, exq.size())
    $display("trigger test done");
    results();
  end
endmodule // vadc_top_tb_top

bind vadc_top vadc_top_asserts i_vadc_top_asserts (.i_clk, .i_rst_b, .i_vme_as_b, .i_vme_ds0_b, .i_vme_ds1_b,
  .i_vme_write_b, .i_vme_am, .i_vme_addr, .i_vme_iack_b, .i_vme_iackin_b, .i_base_sw, .i_irq_sel,
  .o_vme_dtack_oe, .o_vme_iackout_b, .o_vme_irq_oe, .o_gain_sel, .o_dout, .o_settling);

`default_nettype wire
